// >>> hw/agc_config.sv
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
// What this block does
// - Gain code is gain-high bits 7:0 above gain-low bits 7:4.
// - Effective gain is code/4096, plus 1/64 when offset-add bit set.
// - Gain spans zero to 1.015 at full code with offset add.
// - Gain programming applies only when config bit 0 is set.
// - SAR clock is divider input clock divided by field 7:3 plus one.
// - Without burst mode the divider runs from the system clock.
// - In burst mode the divider runs from the separate burst clock.
// - Repeat field 00,01,10,11 selects 1,4,8,16 summed conversions.
// - Done and window interrupts rise only after all repeats accumulate.
// - Non-burst needs a start per conversion; burst self-times the set.
// - Repeated results accumulate separately; the result register takes the final sum in both modes.
module agc_config (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins from the analog side and the burst clock
  input wire logic burstClkIn,
  input wire logic startTrigIn,
  input wire logic convDoneIn,
  input wire logic [11:0] convDataIn,
  // Towards the SAR core
  output logic sarClockTick,
  output logic sarStart,
  output logic [12:0] gainWord,
  output logic irq
);
  import agc_pkg::*;

  logic [7:0] configReg;
  logic [7:0] gainHighReg;
  logic [7:0] gainLowReg;
  logic gainAddReg;
  logic burstReg;
  logic ljustReg;
  logic [31:0] windowReg;
  logic [1:0] irqStatReg;
  logic [1:0] irqMaskReg;
  logic [15:0] resultReg;
  logic [15:0] accReg;
  logic [3:0] countReg;
  logic [4:0] divCntReg;
  logic startPendReg;
  agc_state_t stateReg;
  logic [2:0] burstSyncReg;
  logic [2:0] trigSyncReg;
  logic [2:0] doneSyncReg;
  logic [11:0] dataSync1Reg;
  logic [11:0] dataSync2Reg;

  logic busWrite;
  logic busRead;
  logic divIn;
  logic sarTick;
  logic doneEdge;
  logic swStart;
  logic trigEdge;
  logic launch;
  logic lastConv;
  logic [4:0] divide;
  logic [3:0] lastIdx;
  logic [15:0] sample;
  logic [15:0] sum;
  logic inWindow;

  assign busWrite = clkEn && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign busRead = clkEn && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      burstSyncReg <= 3'h0;
      trigSyncReg <= 3'h0;
      doneSyncReg <= 3'h0;
      dataSync1Reg <= 12'h000;
      dataSync2Reg <= 12'h000;
    end else if (clkEn) begin
      burstSyncReg <= {burstSyncReg[1:0], burstClkIn};
      trigSyncReg <= {trigSyncReg[1:0], startTrigIn};
      doneSyncReg <= {doneSyncReg[1:0], convDoneIn};
      dataSync1Reg <= convDataIn;
      dataSync2Reg <= dataSync1Reg;
    end
  end

  assign trigEdge = trigSyncReg[1] && !trigSyncReg[2];
  assign doneEdge = doneSyncReg[1] && !doneSyncReg[2];

  // Divider input: system clock or rising edges of the burst clock
  assign divIn = burstReg ? (burstSyncReg[1] && !burstSyncReg[2]) : 1'b1;
  assign divide = configReg[CFG_DIV_MSB:CFG_DIV_LSB];
  assign sarTick = divIn && (divCntReg == divide);

  // Divide by field plus one; a tick marks each SAR clock period
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      divCntReg <= 5'h00;
      sarClockTick <= 1'b0;
    end else if (clkEn) begin
      sarClockTick <= sarTick;
      if (divIn) begin
        divCntReg <= (divCntReg >= divide) ? 5'h00 : divCntReg + 5'h01;
      end
    end
  end

  // Gain word in 4096ths; unity when programming is off
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gainWord <= GAIN_UNITY;
    end else if (clkEn) begin
      if (configReg[CFG_GAIN_EN]) begin
        gainWord <= {1'b0, gainHighReg, gainLowReg[7:4]} + (gainAddReg ? GAIN_STEP : 13'h0000);
      end else begin
        gainWord <= GAIN_UNITY;
      end
    end
  end

  // Repeat count decode: last index of the set
  always_comb begin
    unique case (configReg[CFG_RPT_MSB:CFG_RPT_LSB])
      2'b00: lastIdx = 4'h0;
      2'b01: lastIdx = 4'h3;
      2'b10: lastIdx = 4'h7;
      2'b11: lastIdx = 4'hF;
    endcase
  end

  // Left justify only meaningful for single conversions
  assign sample = ljustReg ? {dataSync2Reg, 4'h0} : {4'h0, dataSync2Reg};
  assign sum = accReg + sample;
  assign lastConv = (countReg == lastIdx);
  assign inWindow = (sum >= windowReg[15:0]) && (sum <= windowReg[31:16]);
  assign swStart = busWrite && (wb_adr_i == OFF_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_START];
  // Burst repeats launch themselves; otherwise each waits for a start
  assign launch = sarTick && ((stateReg == SQ_IDLE && startPendReg) ||
                  (stateReg == SQ_NEXT && (burstReg || startPendReg)));

  // Pending start; a new trigger wins over consumption
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      startPendReg <= 1'b0;
    end else if (clkEn) begin
      if (swStart || trigEdge) begin
        startPendReg <= 1'b1;
      end else if (launch && !(stateReg == SQ_NEXT && burstReg)) begin
        startPendReg <= 1'b0;
      end
    end
  end

  // Conversion sequencer and accumulator
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stateReg <= SQ_IDLE;
      accReg <= 16'h0000;
      countReg <= 4'h0;
      resultReg <= 16'h0000;
      sarStart <= 1'b0;
    end else if (clkEn) begin
      sarStart <= launch;
      unique case (stateReg)
        SQ_IDLE: begin
          if (launch) begin
            accReg <= 16'h0000;
            countReg <= 4'h0;
            stateReg <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (doneEdge) begin
            accReg <= sum;
            if (lastConv) begin
              resultReg <= sum;
              stateReg <= SQ_IDLE;
            end else begin
              countReg <= countReg + 4'h1;
              stateReg <= SQ_NEXT;
            end
          end
        end
        SQ_NEXT: begin
          if (launch) begin
            stateReg <= SQ_WAIT;
          end
        end
        default: stateReg <= SQ_IDLE;
      endcase
    end
  end

  // Sticky interrupt status; an event beats a clearing read
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irqStatReg <= 2'h0;
      irq <= 1'b0;
    end else if (clkEn) begin
      for (int i = 0; i < 2; i++) begin
        if (stateReg == SQ_WAIT && doneEdge && lastConv &&
            (i == IRQ_DONE || inWindow)) begin
          irqStatReg[i] <= 1'b1;
        end else if (busRead && wb_adr_i == OFF_IRQ_STAT) begin
          irqStatReg[i] <= 1'b0;
        end
      end
      irq <= |(irqStatReg & irqMaskReg);
    end
  end

  // Software-written registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      configReg <= CONFIG_RST;
      gainHighReg <= GAIN_HIGH_RST;
      gainLowReg <= GAIN_LOW_RST;
      gainAddReg <= GAIN_ADD_RST;
      burstReg <= 1'b0;
      ljustReg <= 1'b0;
      irqMaskReg <= 2'h0;
      windowReg <= WINDOW_RST;
    end else if (busWrite) begin
      unique case (wb_adr_i)
        OFF_CONFIG: if (wb_sel_i[0]) configReg <= wb_dat_i[7:0];
        OFF_GAIN_HIGH: if (wb_sel_i[0]) gainHighReg <= wb_dat_i[7:0];
        OFF_GAIN_LOW: if (wb_sel_i[0]) gainLowReg <= {wb_dat_i[7:4], 4'h0};
        OFF_GAIN_ADD: if (wb_sel_i[0]) gainAddReg <= wb_dat_i[0];
        OFF_CTRL: if (wb_sel_i[0]) begin
          burstReg <= wb_dat_i[CTRL_BURST];
          ljustReg <= wb_dat_i[CTRL_LJUST];
        end
        OFF_IRQ_MASK: if (wb_sel_i[0]) irqMaskReg <= wb_dat_i[1:0];
        OFF_WINDOW: begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) windowReg[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
        default: ;
      endcase
    end
  end

  // Bus answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (clkEn) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (busRead) begin
        unique case (wb_adr_i)
          OFF_CONFIG: wb_dat_o <= {24'h000000, configReg};
          OFF_GAIN_HIGH: wb_dat_o <= {24'h000000, gainHighReg};
          OFF_GAIN_LOW: wb_dat_o <= {24'h000000, gainLowReg};
          OFF_GAIN_ADD: wb_dat_o <= {31'h00000000, gainAddReg};
          OFF_CTRL: wb_dat_o <= {28'h0000000, stateReg != SQ_IDLE, ljustReg, burstReg, 1'b0};
          OFF_RESULT: wb_dat_o <= {16'h0000, resultReg};
          OFF_IRQ_STAT: wb_dat_o <= {30'h00000000, irqStatReg};
          OFF_IRQ_MASK: wb_dat_o <= {30'h00000000, irqMaskReg};
          OFF_WINDOW: wb_dat_o <= windowReg;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Checks
  a_gain_word: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && configReg[CFG_GAIN_EN] && !gainAddReg |=> $past(clkEn) -> gainWord == {1'b0, $past(gainHighReg), $past(gainLowReg[7:4])})
    else $error("gain word not formed from high and low bytes");
  a_gain_offset: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && configReg[CFG_GAIN_EN] && gainAddReg && gainHighReg == 8'hFF && gainLowReg[7:4] == 4'hF
    |=> gainWord == 13'h103F)
    else $error("offset step not added to full scale gain");
  a_gain_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    gainWord <= 13'h103F)
    else $error("gain word above top of range");
  a_gain_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && !configReg[CFG_GAIN_EN] |=> gainWord == GAIN_UNITY)
    else $error("gain applied while disabled");
  // A divider change mid-count resynchronises first, so only check once settled
  a_div_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && $past(clkEn) && !burstReg && !$past(burstReg) &&
    divide == 5'h00 && $past(divide) == 5'h00 |-> sarTick)
    else $error("divide by one missed a tick");
  a_div_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && !burstReg && divide == 5'h01 && sarTick |=> clkEn -> !sarTick)
    else $error("divide by two ticked twice in a row");
  a_burst_div: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && $past(clkEn) && burstReg && $past(burstReg) && sarClockTick |=> !sarClockTick)
    else $error("burst divider ticked on two cycles in a row");
  a_irq_after_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && !irqStatReg[IRQ_DONE] ##1 irqStatReg[IRQ_DONE] |-> $past(lastConv) && $past(stateReg) == SQ_WAIT)
    else $error("done flag before all repeats");
  a_nonburst_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && stateReg == SQ_NEXT && !burstReg && !startPendReg |=> !sarStart)
    else $error("repeat launched without a start");
  a_result_latch: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && stateReg == SQ_WAIT && doneEdge && lastConv |=> resultReg == $past(sum))
    else $error("result not loaded with accumulated sum");
  a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkEn && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  c_single: cover property (@(posedge sys_clk) disable iff (!resetn)
    stateReg == SQ_WAIT && doneEdge && lastIdx == 4'h0);
  c_sixteen: cover property (@(posedge sys_clk) disable iff (!resetn)
    stateReg == SQ_WAIT && doneEdge && lastConv && lastIdx == 4'hF);
  c_burst: cover property (@(posedge sys_clk) disable iff (!resetn)
    burstReg && stateReg == SQ_NEXT && launch);
  c_window: cover property (@(posedge sys_clk) disable iff (!resetn) irqStatReg[IRQ_WIN]);
endmodule // agc_config

// >>> hw/agc_pkg.sv
package agc_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] OFF_GAIN_HIGH = 8'h00;
  localparam logic [7:0] OFF_GAIN_LOW = 8'h04;
  localparam logic [7:0] OFF_GAIN_ADD = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_WINDOW = 8'h1C;
  localparam logic [7:0] OFF_CONFIG = 8'hBC;
  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'hF8;
  localparam logic [7:0] GAIN_HIGH_RST = 8'hFC;
  localparam logic [7:0] GAIN_LOW_RST = 8'h00;
  localparam logic GAIN_ADD_RST = 1'b1;
  localparam logic [31:0] WINDOW_RST = 32'hFFFF0000;
  // Config register fields
  localparam int CFG_DIV_MSB = 7;
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_RPT_MSB = 2;
  localparam int CFG_RPT_LSB = 1;
  localparam int CFG_GAIN_EN = 0;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_BURST = 1;
  localparam int CTRL_LJUST = 2;
  localparam int CTRL_BUSY = 3;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WIN = 1;
  // Gain arithmetic: unity is 4096, the add step is 4096/64
  localparam logic [12:0] GAIN_UNITY = 13'h1000;
  localparam logic [12:0] GAIN_STEP = 13'h0040;
  // Sequencer states
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_WAIT = 2'b01,
    SQ_NEXT = 2'b10
  } agc_state_t;
endpackage

// >>> test/adc_gain_clock_repeat_config_tb_top.sv
`timescale 1ns/100ps
// Register-level test of the converter configuration block
module adc_gain_clock_repeat_config_tb_top;
  import agc_pkg::*;
  logic sys_clk, resetn, burstClkIn, startTrigIn, convDoneIn, sarClockTick, sarStart, irq;
  logic wbCyc, wbStb, wbWe, wbAckO;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI, wbDatO;
  logic [11:0] convDataIn, sampleVal;
  logic [12:0] gainWord;
  int startCount, doneCount, failCount, checkCount, cycles, n;
  int cnt [4] = '{1, 4, 8, 16};
  logic [7:0] gh [4] = '{8'hFF, 8'hFF, 8'h7C, 8'h00};
  logic [7:0] gl [4] = '{8'hF0, 8'hF0, 8'h0F, 8'h00};
  logic ga [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [4:0] dv [3] = '{5'd0, 5'd3, 5'd31};
  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Burst pin at 25 MHz, phase offset from the system clock
  initial begin
    burstClkIn = 1'b0;
    #3;
    forever #20 burstClkIn = ~burstClkIn;
  end
  agc_config dut (.sys_clk(sys_clk), .resetn(resetn), .clkEn(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAckO), .burstClkIn(burstClkIn), .startTrigIn(startTrigIn), .convDoneIn(convDoneIn),
    .convDataIn(convDataIn), .sarClockTick(sarClockTick), .sarStart(sarStart), .gainWord(gainWord),
    .irq(irq));
  agc_sar_model sar (.sys_clk(sys_clk), .resetn(resetn), .sarStart(sarStart), .sampleVal(sampleVal),
    .convDoneIn(convDoneIn), .convDataIn(convDataIn), .startCount(startCount), .doneCount(doneCount));
  task automatic finishTest();
    $display("checks=%0d mismatches=%0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      finishTest();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle: called just after a rising edge; request held until ack is sampled high
  // Reads right after an edge see the values that stood at that edge
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    @(posedge sys_clk);
    while (wbAckO !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Cycles between two divider ticks
  task automatic tickGap(input int e);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (sarClockTick !== 1'b1 && k < 500) begin
      @(negedge sys_clk);
      k++;
    end
    @(negedge sys_clk);
    k = 1;
    while (sarClockTick !== 1'b1 && k < 500) begin
      @(negedge sys_clk);
      k++;
    end
    chk(32'(k), 32'(e));
    @(posedge sys_clk);
  endtask
  // Slack after the pin falls covers sync and accumulate
  task automatic waitConv(input int t);
    while (doneCount < t) begin
      @(negedge sys_clk);
    end
    repeat (2) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  initial begin
    resetn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    startTrigIn = 1'b0;
    sampleVal = 12'h000;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdChk(OFF_CONFIG, 32'(CONFIG_RST));
    rdChk(OFF_GAIN_HIGH, 32'(GAIN_HIGH_RST));
    rdChk(OFF_GAIN_ADD, 32'(GAIN_ADD_RST));
    rdChk(8'h40, 32'h0);
    chk(32'(gainWord), 32'(GAIN_UNITY));
    // Gain table with programming on, low nibble of gain-low ignored
    wr(OFF_CONFIG, 32'h01);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_GAIN_HIGH, 32'(gh[i]));
      wr(OFF_GAIN_LOW, 32'(gl[i]));
      wr(OFF_GAIN_ADD, 32'(ga[i]));
      rdChk(OFF_GAIN_LOW, 32'(gl[i] & 8'hF0));
      chk(32'(gainWord), 32'({gh[i], gl[i][7:4]}) + (ga[i] ? 32'd64 : 32'd0));
    end
    wr(OFF_CONFIG, 32'h00);
    chk(32'(gainWord), 32'(GAIN_UNITY));
    // Divider from the system clock, smallest to largest field
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CONFIG, 32'({dv[i], 3'b000}));
      tickGap(int'(dv[i]) + 1);
    end
    wr(OFF_CTRL, 32'h2);
    wr(OFF_CONFIG, 32'h08);
    tickGap(10);
    wr(OFF_CTRL, 32'h0);
    // One start per conversion; irq masked on the first set
    for (int r = 0; r < 4; r++) begin
      wr(OFF_CONFIG, 32'({5'd1, 2'(r), 1'b0}));
      sampleVal <= (r == 3) ? 12'hFFF : 12'h123 + 12'(r);
      for (int i = 0; i < cnt[r]; i++) begin
        rdChk(OFF_IRQ_STAT, 32'h0);
        n = doneCount;
        wr(OFF_CTRL, 32'h1);
        waitConv(n + 1);
        chk(32'(startCount), 32'(n + 1));
      end
      rdChk(OFF_RESULT, 32'(cnt[r]) * 32'(sampleVal));
      if (r == 0) begin
        chk(32'(irq), 32'h0);
        wr(OFF_IRQ_MASK, 32'h3);
      end
      chk(32'(irq), 32'h1);
      rdChk(OFF_IRQ_STAT, 32'h3);
      chk(32'(irq), 32'h0);
    end
    // Burst: one trigger pulse runs the whole set of four
    wr(OFF_CONFIG, 32'({5'd3, 2'b01, 1'b0}));
    wr(OFF_CTRL, 32'h2);
    sampleVal <= 12'h0AB;
    n = doneCount;
    startTrigIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    startTrigIn <= 1'b0;
    waitConv(n + 4);
    rdChk(OFF_RESULT, 32'h2AC);
    rdChk(OFF_IRQ_STAT, 32'h3);
    repeat (60) @(posedge sys_clk);
    chk(32'(startCount), 32'(n + 4));
    finishTest();
  end
endmodule // adc_gain_clock_repeat_config_tb_top

// >>> test/agc_sar_model.sv
`timescale 1ns/100ps
// Far-side SAR core: answers each start after a fixed latency
module agc_sar_model #(parameter int LAT = 6) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // From the block
  input wire logic sarStart,
  input wire logic [11:0] sampleVal,
  // Answer to the block
  output logic convDoneIn,
  output logic [11:0] convDataIn,
  output int startCount,
  output int doneCount
);
  int timer;
  int pend;
  // Starts that land while busy queue up, as a real core would lose none
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      timer <= 0;
      pend <= 0;
      startCount <= 0;
      doneCount <= 0;
      convDoneIn <= 1'b0;
      convDataIn <= 12'h000;
    end else begin
      if (sarStart)
        startCount <= startCount + 1;
      pend <= pend + int'(sarStart) - int'(timer == 0 && pend != 0);
      if (timer == 0 && pend != 0)
        timer <= LAT + 4;
      else if (timer != 0)
        timer <= timer - 1;
      // Data held 4 cycles past done, then scrambled
      if (timer == 5) begin
        convDoneIn <= 1'b1;
        convDataIn <= sampleVal;
      end
      if (timer == 1) begin
        convDoneIn <= 1'b0;
        convDataIn <= ~sampleVal;
        doneCount <= doneCount + 1;
      end
    end
  end
endmodule // agc_sar_model
